// *** clr_map.vh ***
// constants shared by the character display ram access block
`ifndef CLR_MAP_VH
`define CLR_MAP_VH

// clock period and execution times; cycle counts are sized to fit the 13-bit timers at 10 ns
`define CLR_CLK_NS 10
`define CLR_T_INSTR_NS 39000
`define CLR_T_DATA_NS 43000
`define CLR_T_INSTR_CYC 13'h0F3C
`define CLR_T_DATA_CYC 13'h10CC

// text ram address ranges
`define CLR_ONE_LAST 7'h4F
`define CLR_ROW1_FIRST 7'h00
`define CLR_ROW1_LAST 7'h27
`define CLR_ROW2_FIRST 7'h40
`define CLR_ROW2_LAST 7'h67

// instruction field positions
`define CLR_B_TEXT 7
`define CLR_B_GLYPH 6
`define CLR_B_FUNC 5
`define CLR_B_SHIFT 4
`define CLR_B_ENTRY 2
`define CLR_B_DL 4
`define CLR_B_N 3
`define CLR_B_SC 3
`define CLR_B_RL 2
`define CLR_B_ID 1

// reset values
`define CLR_DL_RST 1'b1
`define CLR_N_RST 1'b0
`define CLR_ID_RST 1'b1
`define CLR_AC_RST 7'h00

// write buffer shape
`define CLR_FIFO_W 16
`define CLR_FIFO_D 4
`define CLR_FIFO_AW 2

`endif

// *** clr_fifo.v ***
// small synchronous fifo carrying pending ram writes
`default_nettype none

module clr_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;

    // full and empty come straight from the occupancy count
    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // storage has no reset; only the pointers and the count need a defined state
    always @(posedge clk_sys)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // pointer and count update
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push & ~pop)
            begin
                count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
            end
            else if (pop & ~push)
            begin
                count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
            end
        end
    end

endmodule // clr_fifo

`default_nettype wire

// *** clr_ctrl.v ***
// character display controller: address set, busy/address read and ram data access
//
// Summary of operation
// - write, select low, bits 7..6 = 01: load six-bit glyph address into counter
// - write, select low, bit 7 high: load seven-bit text address into counter
// - one-row mode: text addresses run 00 to 4F
// - two-row mode: row one 00 to 27, row two 40 to 67
// - read, select low: busy on line 7, address counter on lines 6..0
// - data write stores byte into ram chosen by last address set
// - counter steps by one after each data write, per entry direction
// - data read returns byte from ram chosen by last address set
// - first read without prior address set is invalid; host discards it
// - cursor shift in text ram reloads output data register like a text address set
// - counter steps by one after each data read, per entry direction
// - display shift after glyph read is not guaranteed
// - read after write returns previously latched data, not new address
// - entry direction high increments, low decrements; glyph ram alike
// - bus width bit low: each byte moves as two four-bit transfers
`include "clr_map.vh"
`default_nettype none

module clr_ctrl #(
    parameter [12:0] DATA_CYC = `CLR_T_DATA_CYC
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // host bus pins
    input wire reg_select_line,
    input wire rw_line,
    input wire enable_line,
    input wire [7:0] db_in,
    output reg [7:0] db_out,
    output wire db_oe_n,
    // status
    output wire busy_flag,
    output wire [6:0] addr_counter,
    output wire glyph_sel,
    output wire entry_inc,
    output wire two_line,
    output wire bus_width_bit
);

    localparam [12:0] INSTR_CYC = `CLR_T_INSTR_CYC;

    // pin synchronisers: stage one is read only by stage two
    reg rs_s1_reg;
    reg rs_s2_reg;
    reg rw_s1_reg;
    reg rw_s2_reg;
    reg e_s1_reg;
    reg e_s2_reg;
    reg e_s3_reg;
    reg [7:0] db_s1_reg;
    reg [7:0] db_s2_reg;

    // control state
    reg [6:0] ac_reg;
    reg glyph_reg;
    reg inc_reg;
    reg two_reg;
    reg dl_reg;
    reg phase_reg;
    reg [3:0] hi_reg;
    reg [7:0] rd_latch_reg;
    reg prefetch_reg;
    reg [12:0] instr_cnt_reg;
    reg [12:0] wr_cnt_reg;

    // ram arrays
    reg [7:0] text_ram [0:127];
    reg [7:0] glyph_ram [0:63];

    wire e_rise;
    wire e_fall;
    wire byte_done;
    wire [7:0] byte_val;
    wire instr_busy;
    wire [7:0] rd_val;
    wire fifo_in_valid;
    wire fifo_in_ready;
    wire [15:0] fifo_in_data;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [15:0] fifo_out_data;

    // one step of the counter, wrapping inside the valid ranges
    function [6:0] clr_step;
        input [6:0] a;
        input inc;
        input glyph;
        input two;
        begin
            if (glyph)
            begin
                clr_step = {1'b0, (inc ? a[5:0] + 6'h01 : a[5:0] - 6'h01)};
            end
            else if (!two)
            begin
                if (inc)
                    clr_step = (a >= `CLR_ONE_LAST) ? 7'h00 : a + 7'h01;
                else
                    clr_step = (a == 7'h00 || a > `CLR_ONE_LAST) ? `CLR_ONE_LAST : a - 7'h01;
            end
            else if (inc)
            begin
                if (a == `CLR_ROW1_LAST)
                    clr_step = `CLR_ROW2_FIRST;
                else if (a >= `CLR_ROW2_LAST)
                    clr_step = `CLR_ROW1_FIRST;
                else
                    clr_step = a + 7'h01;
            end
            else
            begin
                if (a == `CLR_ROW2_FIRST)
                    clr_step = `CLR_ROW1_LAST;
                else if (a == `CLR_ROW1_FIRST || a > `CLR_ROW2_LAST)
                    clr_step = `CLR_ROW2_LAST;
                else
                    clr_step = a - 7'h01;
            end
        end
    endfunction

    // pins come from the host's domain, so two flops before use
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rs_s1_reg <= 1'b0;
            rs_s2_reg <= 1'b0;
            rw_s1_reg <= 1'b0;
            rw_s2_reg <= 1'b0;
            e_s1_reg <= 1'b0;
            e_s2_reg <= 1'b0;
            e_s3_reg <= 1'b0;
            db_s1_reg <= 8'h00;
            db_s2_reg <= 8'h00;
        end
        else
        begin
            rs_s1_reg <= reg_select_line;
            rs_s2_reg <= rs_s1_reg;
            rw_s1_reg <= rw_line;
            rw_s2_reg <= rw_s1_reg;
            e_s1_reg <= enable_line;
            e_s2_reg <= e_s1_reg;
            e_s3_reg <= e_s2_reg;
            db_s1_reg <= db_in;
            db_s2_reg <= db_s1_reg;
        end
    end

    // strobe edges seen after synchronisation
    assign e_rise = e_s2_reg & ~e_s3_reg;
    assign e_fall = e_s3_reg & ~e_s2_reg;

    // a byte is complete on every strobe in wide mode, every second in narrow mode
    assign byte_done = e_fall & (dl_reg | phase_reg);
    assign byte_val = dl_reg ? db_s2_reg : {hi_reg, db_s2_reg[7:4]};

    // busy covers a running instruction and a full write buffer
    assign instr_busy = (instr_cnt_reg != 13'h0000);
    assign busy_flag = instr_busy | ~fifo_in_ready;

    // value presented for a read: status word or the latched data byte
    assign rd_val = rs_s2_reg ? rd_latch_reg : {busy_flag, ac_reg};

    // data writes queue with their target ram and address
    assign fifo_in_valid = byte_done & rs_s2_reg & ~rw_s2_reg & ~instr_busy;
    assign fifo_in_data = {glyph_reg, ac_reg, byte_val};
    assign fifo_out_ready = (wr_cnt_reg == 13'h0000);

    // drive the data lines only while the host reads with the strobe high
    assign db_oe_n = ~(rw_s2_reg & e_s2_reg);

    // status outputs
    assign addr_counter = ac_reg;
    assign glyph_sel = glyph_reg;
    assign entry_inc = inc_reg;
    assign two_line = two_reg;
    assign bus_width_bit = dl_reg;

    // read data is captured on the rising strobe; narrow mode sends upper nibble first
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            db_out <= 8'h00;
        end
        else if (e_rise & rw_s2_reg)
        begin
            if (dl_reg)
                db_out <= rd_val;
            else if (!phase_reg)
                db_out <= {rd_val[7:4], 4'h0};
            else
                db_out <= {rd_val[3:0], 4'h0};
        end
    end

    // nibble pairing; the phase advances on every falling strobe in narrow mode
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_reg <= 1'b0;
            hi_reg <= 4'h0;
        end
        else if (e_fall & ~dl_reg)
        begin
            phase_reg <= ~phase_reg;
            if (!phase_reg)
                hi_reg <= db_s2_reg[7:4];
        end
    end

    // instruction decode, counter stepping and prefetch request
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ac_reg <= `CLR_AC_RST;
            glyph_reg <= 1'b0;
            inc_reg <= `CLR_ID_RST;
            two_reg <= `CLR_N_RST;
            dl_reg <= `CLR_DL_RST;
            prefetch_reg <= 1'b0;
            instr_cnt_reg <= 13'h0000;
        end
        else
        begin
            prefetch_reg <= 1'b0;
            if (instr_busy)
                instr_cnt_reg <= instr_cnt_reg - 13'h0001;
            if (byte_done & ~rs_s2_reg & ~rw_s2_reg & ~instr_busy)
            begin
                // commands arriving while an instruction runs are dropped; the host must poll first
                instr_cnt_reg <= INSTR_CYC;
                if (byte_val[`CLR_B_TEXT])
                begin
                    ac_reg <= byte_val[6:0];
                    glyph_reg <= 1'b0;
                    prefetch_reg <= 1'b1;
                end
                else if (byte_val[`CLR_B_GLYPH])
                begin
                    ac_reg <= {1'b0, byte_val[5:0]};
                    glyph_reg <= 1'b1;
                    prefetch_reg <= 1'b1;
                end
                else if (byte_val[`CLR_B_FUNC])
                begin
                    dl_reg <= byte_val[`CLR_B_DL];
                    two_reg <= byte_val[`CLR_B_N];
                end
                else if (byte_val[`CLR_B_SHIFT])
                begin
                    // only a cursor shift moves the counter; display shift leaves it
                    if (!byte_val[`CLR_B_SC])
                    begin
                        ac_reg <= clr_step(ac_reg, byte_val[`CLR_B_RL], glyph_reg, two_reg);
                        prefetch_reg <= ~glyph_reg;
                    end
                end
                else if (byte_val[`CLR_B_ENTRY])
                begin
                    inc_reg <= byte_val[`CLR_B_ID];
                end
            end
            else if (fifo_in_valid & fifo_in_ready)
            begin
                // after a write the counter moves on but no new byte is fetched
                ac_reg <= clr_step(ac_reg, inc_reg, glyph_reg, two_reg);
            end
            else if (byte_done & rs_s2_reg & rw_s2_reg)
            begin
                ac_reg <= clr_step(ac_reg, inc_reg, glyph_reg, two_reg);
                prefetch_reg <= 1'b1;
                instr_cnt_reg <= DATA_CYC;
            end
        end
    end

    // output data register; holds zero from reset until the first fetch
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_latch_reg <= 8'h00;
        end
        else if (prefetch_reg)
        begin
            // without an address set the first read returns this stale value
            if (glyph_reg)
                rd_latch_reg <= glyph_ram[ac_reg[5:0]];
            else
                rd_latch_reg <= text_ram[ac_reg];
        end
    end

    // write drain timer paces the ram updates and lets the buffer fill
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_cnt_reg <= 13'h0000;
        end
        else if (fifo_out_valid & fifo_out_ready)
        begin
            wr_cnt_reg <= DATA_CYC;
        end
        else if (wr_cnt_reg != 13'h0000)
        begin
            wr_cnt_reg <= wr_cnt_reg - 13'h0001;
        end
    end

    // ram update from the head of the write buffer
    always @(posedge clk_sys)
    begin
        if (fifo_out_valid & fifo_out_ready)
        begin
            if (fifo_out_data[15])
                glyph_ram[fifo_out_data[13:8]] <= fifo_out_data[7:0];
            else
                text_ram[fifo_out_data[14:8]] <= fifo_out_data[7:0];
        end
    end

    // pending data writes
    clr_fifo #(
        .WIDTH(`CLR_FIFO_W),
        .DEPTH(`CLR_FIFO_D),
        .AW(`CLR_FIFO_AW)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

endmodule // clr_ctrl

`default_nettype wire

// *** clr_ctrl_sva.sv ***
// concurrent checks on the pins of the display ram access block
`default_nettype none
module clr_ctrl_sva #(
    parameter [12:0] DATA_CYC = 13'h10CC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // host bus pins
    input wire logic reg_select_line,
    input wire logic rw_line,
    input wire logic enable_line,
    input wire logic [7:0] db_in,
    input wire logic [7:0] db_out,
    input wire logic db_oe_n,
    // status
    input wire logic busy_flag,
    input wire logic [6:0] addr_counter,
    input wire logic glyph_sel,
    input wire logic entry_inc,
    input wire logic two_line,
    input wire logic bus_width_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // a byte taken at the falling strobe while idle, pins then held
    sequence taken(logic s, logic r);
        $fell(enable_line) && reg_select_line == s && rw_line == r && !busy_flag && bus_width_bit
        ##1 ($stable(db_in) && !enable_line)[*4];
    endsequence

    // a status read whose strobe is held long enough for the answer
    sequence st_rd;
        $rose(enable_line) && !reg_select_line && rw_line
        ##1 (enable_line && !reg_select_line && rw_line)[*4];
    endsequence

    a_oe_src: assert property (!db_oe_n |-> $past(rw_line, 2))
        else $error("output enable low without a read");
    a_oe_on: assert property (st_rd |-> !db_oe_n)
        else $error("output enable not low during read");
    a_stat_val: assert property (st_rd |-> !bus_width_bit || db_out[6:0] == addr_counter)
        else $error("status read does not show address counter");
    a_nib_low: assert property (st_rd |-> bus_width_bit || db_out[3:0] == 4'h0)
        else $error("narrow read lower lines not zero");
    a_text_set: assert property (taken(1'b0, 1'b0) ##0 db_in[7] |-> !glyph_sel && addr_counter == db_in[6:0])
        else $error("text address not loaded");
    a_glyph_set: assert property (taken(1'b0, 1'b0) ##0 db_in[7:6] == 2'b01
        |-> glyph_sel && addr_counter == {1'b0, db_in[5:0]})
        else $error("glyph address not loaded");
    a_instr_busy: assert property (taken(1'b0, 1'b0) |-> busy_flag)
        else $error("busy not raised by instruction");
    a_data_step: assert property (taken(1'b1, rw_line) |-> addr_counter != $past(addr_counter, 5))
        else $error("address counter did not step");
endmodule // clr_ctrl_sva
`default_nettype wire

// *** clr_host.sv ***
// host processor model driving the display bus pins
`default_nettype none
module clr_host (
    // clock
    input wire logic clk_sys,
    // bus pins
    output var logic reg_select_line,
    output var logic rw_line,
    output var logic enable_line,
    output logic [7:0] db_in,
    input wire logic [7:0] db_out,
    input wire logic db_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic narrow = 1'b0;
    logic drv = 1'b0;
    logic [7:0] dq = 8'h00;
    logic [7:0] last = 8'h00;

    // idle pins at time zero, strobe low
    initial
    begin
        reg_select_line = 1'b0;
        rw_line = 1'b0;
        enable_line = 1'b0;
    end

    // released lines toggle so no stale byte can pass for data
    assign db_in = drv ? dq : (!db_oe_n ? db_out : ~last);
    always @(posedge clk_sys) last <= db_in;

    // one strobe: 3 clk setup, 6 clk high, 5 clk hold after the fall
    task automatic strobe(input logic s, input logic r, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_sys);
        reg_select_line <= s;
        rw_line <= r;
        dq <= d;
        drv <= !r;
        repeat (3) @(posedge clk_sys);
        enable_line <= 1'b1;
        repeat (6) @(posedge clk_sys);
        q = db_out;
        enable_line <= 1'b0;
        repeat (5) @(posedge clk_sys);
        drv <= 1'b0;
    endtask

    // whole byte, split into nibbles when narrow, upper first
    task automatic xfer(input logic s, input logic r, input logic [7:0] d, output logic [7:0] q);
        logic [7:0] h;
        logic [7:0] l;
        if (!narrow)
        begin
            strobe(s, r, d, q);
        end
        else
        begin
            strobe(s, r, d, h);
            strobe(s, r, {d[3:0], 4'h0}, l);
            q = {h[7:4], l[7:4]};
        end
    endtask
endmodule // clr_host
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the display ram access block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DC = 40;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic reg_select_line, rw_line, enable_line, db_oe_n, busy_flag;
    logic glyph_sel, entry_inc, two_line, bus_width_bit;
    logic [7:0] db_in, db_out;
    logic [6:0] addr_counter;
    int num_errors = 0;
    int compares = 0;

    clr_ctrl #(.DATA_CYC(13'h0028)) dut_u (.clk_sys, .rst_n, .reg_select_line, .rw_line, .enable_line,
        .db_in, .db_out, .db_oe_n, .busy_flag, .addr_counter, .glyph_sel, .entry_inc, .two_line, .bus_width_bit);
    clr_host host_u (.clk_sys, .reg_select_line, .rw_line, .enable_line, .db_in, .db_out, .db_oe_n);

    // 100 MHz clock
    initial forever #5 clk_sys = ~clk_sys;

    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(logic s, logic [7:0] d);
        logic [7:0] q;
        host_u.xfer(s, 1'b0, d, q);
    endtask

    task automatic rd(logic s, output logic [7:0] q);
        host_u.xfer(s, 1'b1, 8'h00, q);
    endtask

    // poll status under a bound before the next instruction
    task automatic idle;
        logic [7:0] q;
        int n;
        q = 8'hFF;
        n = 0;
        while (q[7] !== 1'b0 && n < 500)
        begin
            rd(1'b0, q);
            n++;
        end
        chk("busy", 8'h00, {7'h00, q[7]});
    endtask

    task automatic cmd(logic [7:0] d);
        wr(1'b0, d);
        idle();
    endtask

    // queued writes need one data time each to land
    task automatic drain;
        repeat (5 * DC) @(posedge clk_sys);
    endtask

    task automatic t_reset;
        logic [7:0] q;
        chk("reset flags", 8'h15, {2'b00, glyph_sel, entry_inc, two_line, bus_width_bit, busy_flag, db_oe_n});
        chk("reset counter", 8'h00, 8'(addr_counter));
        // no address set yet: the first byte is the stale latch, which a host throws away
        rd(1'b1, q);
        chk("first read", 8'h00, q);
        idle();
    endtask

    task automatic t_text;
        logic [7:0] q;
        wr(1'b0, 8'hC4);
        rd(1'b0, q);
        chk("status busy", 8'hC4, q);
        idle();
        chk("text set", 8'h44, {glyph_sel, addr_counter});
        wr(1'b1, 8'hA5);
        chk("step wr", 8'h45, 8'(addr_counter));
        wr(1'b1, 8'h3C);
        wr(1'b1, 8'h77);
        drain();
        cmd(8'hC4);
        rd(1'b1, q);
        chk("read 44", 8'hA5, q);
        chk("step rd", 8'h45, 8'(addr_counter));
        idle();
        wr(1'b1, 8'h5A);
        rd(1'b1, q);
        chk("read after write", 8'h3C, q);
        idle();
        drain();
        cmd(8'h10);
        chk("shift left", 8'h46, 8'(addr_counter));
        rd(1'b1, q);
        chk("read after shift", 8'h77, q);
        idle();
    endtask

    task automatic t_fifo;
        logic seen;
        logic [7:0] q;
        seen = 1'b0;
        cmd(8'h7C);
        chk("glyph set", 8'hBC, {glyph_sel, addr_counter});
        repeat (10)
        begin
            wr(1'b1, 8'h2E);
            if (busy_flag === 1'b1) seen = 1'b1;
        end
        chk("fifo full", 8'h01, {7'h00, seen});
        drain();
        chk("fifo drained", 8'h00, {7'h00, busy_flag});
        // at least five writes land, so glyph entry zero holds the pattern
        cmd(8'h40);
        rd(1'b1, q);
        chk("glyph read", 8'h2E, q);
        idle();
        cmd(8'h18);
        chk("shift after glyph read", 8'h81, {glyph_sel, addr_counter});
    endtask

    task automatic t_mode;
        cmd(8'h04);
        chk("entry dec", 8'h00, {7'h00, entry_inc});
        cmd(8'h80);
        wr(1'b1, 8'h22);
        chk("one row wrap", 8'h4F, 8'(addr_counter));
        cmd(8'h38);
        chk("two rows", 8'h01, {7'h00, two_line});
        cmd(8'hC0);
        wr(1'b1, 8'h11);
        chk("row wrap", 8'h27, 8'(addr_counter));
        drain();
    endtask

    task automatic t_nib;
        logic [7:0] q;
        // the device is narrow as soon as the byte is taken, so polling must be in nibbles
        wr(1'b0, 8'h28);
        host_u.narrow = 1'b1;
        idle();
        chk("narrow", 8'h00, {7'h00, bus_width_bit});
        wr(1'b0, 8'hA5);
        rd(1'b0, q);
        chk("narrow status", 8'hA5, q);
        idle();
        chk("narrow set", 8'h25, 8'(addr_counter));
    endtask

    task automatic give_verdict;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_text();
        t_fifo();
        t_mode();
        t_nib();
        give_verdict();
    end

    // watchdog well past the expected 48k cycles
    initial
    begin
        #700000;
        num_errors++;
        give_verdict();
    end
endmodule // tb

bind clr_ctrl clr_ctrl_sva #(.DATA_CYC(DATA_CYC)) chk_u (.clk_sys, .rst_n, .reg_select_line, .rw_line,
    .enable_line, .db_in, .db_out, .db_oe_n, .busy_flag, .addr_counter, .glyph_sel, .entry_inc, .two_line,
    .bus_width_bit);
`default_nettype wire
